// file: src/egress_sched_pkg.sv
// constants, register map and types of the egress scheduler and shaper
package egress_sched_pkg;
   // clock and shaper tick
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_US = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
   localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
   // queue count and widths
   localparam int NUM_Q = 8;
   localparam int RATE_W = 20;
   // register byte offsets
   localparam logic [7:0] MODE_OFF = 8'h00;
   localparam logic [7:0] PSHAPE_OFF = 8'h04;
   localparam logic [7:0] STATUS_OFF = 8'h08;
   localparam logic [7:0] QSHAPE_OFF = 8'h20;
   localparam logic [7:0] QWEIGHT_OFF = 8'h40;
   localparam logic [7:0] QPCT_OFF = 8'h60;
   // shaper register fields
   localparam int UNIT_BIT = 20;
   localparam int EN_BIT = 21;
   localparam int EXCESS_BIT = 22;
   // reset values and limits
   localparam logic [6:0] WEIGHT_RST = 7'd17;
   localparam logic [6:0] WEIGHT_MIN = 7'd1;
   localparam logic [6:0] WEIGHT_MAX = 7'd100;
   localparam logic [19:0] RATE_RST = 20'd500;
   localparam logic [19:0] KBPS_MIN = 20'd100;
   localparam logic [19:0] KBPS_MAX = 20'd1000000;
   localparam logic [19:0] MBPS_MIN = 20'd1;
   localparam logic [19:0] MBPS_MAX = 20'd3300;
   localparam logic [7:0] PCT_NA = 8'hFF;
   // deficit quantum per weight unit, bytes
   localparam logic [15:0] QUANTUM = 16'd64;
   // shaper credit in millibits; cap is the allowed burst
   localparam logic signed [39:0] MBIT_PER_BYTE = 40'sd8000;
   localparam logic signed [39:0] MBPS_SCALE = 40'sd1000;
   localparam logic signed [39:0] CREDIT_CAP = 40'sd96_000_000;
   // frame offer state machine
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_OFFER = 3'b010,
      ST_BUSY  = 3'b100
   } tx_state_t;
endpackage

// file: src/rate_shaper.sv
// token bucket rate shaper, one per queue and one per port
`timescale 1ns/1ns
`default_nettype none
module rate_shaper
   import egress_sched_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic enable,
   input wire logic [19:0] rate,
   input wire logic mbps,
   input wire logic charge,
   input wire logic [15:0] charge_bytes,
   output logic allow
);
   logic signed [39:0] credit; // millibits, may go negative
   logic signed [39:0] fill; // credit gained per tick
   logic signed [39:0] cost; // credit spent by a frame
   logic signed [39:0] next_credit;

   // kbps adds rate millibits per microsecond, Mbps a thousand times that
   always_comb begin
      fill = mbps ? 40'(signed'({1'b0, rate})) * MBPS_SCALE : 40'(signed'({1'b0, rate}));
      cost = 40'(signed'({1'b0, charge_bytes})) * MBIT_PER_BYTE;
      next_credit = credit;
      if (tick) begin
         next_credit = next_credit + fill;
      end
      if (next_credit > CREDIT_CAP) begin
         next_credit = CREDIT_CAP;
      end
      if (charge) begin
         next_credit = next_credit - cost;
      end
   end

   // debt holds frames back
   // a frame may overdraw; the debt is then repaid at the set rate
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         credit <= '0;
      end else if (!enable) begin
         credit <= '0; // disabled: no stored burst
      end else begin
         credit <= next_credit;
      end
   end

   assign allow = !enable || (credit >= 0);
endmodule
`default_nettype wire

// file: src/egress_port_scheduler_shaper.sv
// egress port scheduler with queue and port shapers behind an ahb-lite slave
//
// Contract
// - strict mode serves highest non-empty queue first
// - lower queues starve while higher stays busy
// - per-port mode: strict or weighted only
// - weighted mode serves queues in rotation
// - weights bite only when port congested
// - congested share proportional to queue weight
// - weight 1 to 100, resets to 17
// - weight readable as percent of total in weighted mode; strict mode reads FF
// - per-queue shaper enable; clear means unlimited
// - queue rate resets 500, range-checked per unit
// - excess bit lets queue use spare bandwidth
// - port shaper limits aggregate egress rate
// - port rate resets 500, same limits
// - port unit kbps or Mbps, resets kbps
// - mode and weights readable for overview
// - eight queues plus port shaper, status shown
`timescale 1ns/1ns
`default_nettype none
module egress_port_scheduler_shaper
   import egress_sched_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] q_nonempty,
   output logic tx_valid,
   output logic [2:0] tx_queue,
   input wire logic tx_ready,
   input wire logic tx_done,
   input wire logic [15:0] tx_bytes
);
   // configuration
   logic strict_order_mode; // 1 strict, 0 weighted
   logic [6:0] queue_weight_entry [NUM_Q];
   logic [19:0] q_rate [NUM_Q];
   logic [7:0] q_unit; // 1 = Mbps
   logic [7:0] q_shape_en;
   logic [7:0] q_excess;
   logic [19:0] p_rate;
   logic p_unit;
   logic p_shape_en;
   // bus data phase
   logic wr_pend;
   logic [7:0] wr_addr;
   // scheduler state
   tx_state_t state;
   logic [2:0] rr_ptr; // next queue in rotation
   logic signed [23:0] deficit [NUM_Q]; // bytes left this round
   logic tick;
   logic [6:0] tick_cnt;
   logic [7:0] q_allow;
   logic p_allow;
   logic [7:0] shaped;
   logic [7:0] spare;
   logic [7:0] cand;
   logic [7:0] cand_def;
   logic pick_ok;
   logic [2:0] pick_q;
   logic refill;
   logic done_now;
   logic [9:0] weight_sum;

   // rate limit for the unit in force
   function automatic logic rate_ok(input logic [19:0] r, input logic mbps);
      if (mbps) begin
         rate_ok = (r >= MBPS_MIN) && (r <= MBPS_MAX);
      end else begin
         rate_ok = (r >= KBPS_MIN) && (r <= KBPS_MAX);
      end
   endfunction

   // highest set bit of a mask
   function automatic logic [3:0] pick_high(input logic [7:0] m);
      pick_high = 4'h0;
      for (int i = 0; i < NUM_Q; i++) begin
         if (m[i]) begin
            pick_high = {1'b1, 3'(i)};
         end
      end
   endfunction

   // first set bit at or after the pointer, wrapping
   function automatic logic [3:0] pick_rr(input logic [7:0] m, input logic [2:0] p);
      logic [2:0] k;
      pick_rr = 4'h0;
      for (int i = NUM_Q - 1; i >= 0; i--) begin
         k = p + 3'(i);
         if (m[k]) begin
            pick_rr = {1'b1, k};
         end
      end
   endfunction

   // one-microsecond tick for the shapers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
      end else if (tick_cnt == TICK_LAST) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 7'd1;
      end
   end
   assign tick = (tick_cnt == TICK_LAST);

   assign done_now = (state == ST_BUSY) && tx_done;

   for (genvar g = 0; g < NUM_Q; g++) begin : g_qshaper
      rate_shaper u_qshaper (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .tick(tick),
         .enable(q_shape_en[g]),
         .rate(q_rate[g]),
         .mbps(q_unit[g]),
         .charge(done_now && (tx_queue == 3'(g))),
         .charge_bytes(tx_bytes),
         .allow(q_allow[g])
      );
   end

   rate_shaper u_pshaper (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tick(tick),
      .enable(p_shape_en),
      .rate(p_rate),
      .mbps(p_unit),
      .charge(done_now),
      .charge_bytes(tx_bytes),
      .allow(p_allow)
   );

   // candidates for the next frame
   always_comb begin
      shaped = q_nonempty & q_allow;
      spare = q_nonempty & ~q_allow & q_excess;
      // excess only when nothing in-rate waits
      cand = (shaped != 8'h00) ? shaped : spare;
      if (!p_allow) begin
         cand = 8'h00; // port over its rate: hold all
      end
      for (int i = 0; i < NUM_Q; i++) begin
         cand_def[i] = cand[i] && (deficit[i] > 0);
      end
      pick_ok = 1'b0;
      pick_q = 3'd0;
      refill = 1'b0;
      if (strict_order_mode) begin
         {pick_ok, pick_q} = pick_high(cand);
      end else if (cand_def != 8'h00) begin
         {pick_ok, pick_q} = pick_rr(cand_def, rr_ptr);
      end else if ((cand != 8'h00) && (state == ST_IDLE)) begin
         refill = 1'b1; // all spent: new round; idle only, so no charge is lost
      end
   end

   // frame offer handshake toward transmit logic
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         tx_queue <= 3'd0;
      end else begin
         case (state)
            ST_IDLE: begin
               // rechecked for each frame, so lower queues wait
               if (pick_ok && (state == ST_IDLE)) begin
                  tx_queue <= pick_q;
                  state <= ST_OFFER;
               end
            end
            ST_OFFER: begin
               if (tx_ready) begin
                  state <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (tx_done) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
   assign tx_valid = (state == ST_OFFER);

   // deficit counters of the weighted rotation
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_Q; i++) begin
            deficit[i] <= '0;
         end
         rr_ptr <= 3'd0;
      end else if (strict_order_mode) begin
         for (int i = 0; i < NUM_Q; i++) begin
            deficit[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_Q; i++) begin
            if (refill && cand[i]) begin
               deficit[i] <= deficit[i] + 24'(QUANTUM * queue_weight_entry[i]);
            end else if (done_now && (tx_queue == 3'(i))) begin
               deficit[i] <= deficit[i] - 24'(signed'({1'b0, tx_bytes}));
            end else if (!q_nonempty[i] && !(state != ST_IDLE && tx_queue == 3'(i))) begin
               deficit[i] <= '0; // idle queue banks nothing
            end
         end
         // refill on demand keeps the port work-conserving
         if (done_now) begin
            if (deficit[tx_queue] > 24'(signed'({1'b0, tx_bytes}))) begin
               rr_ptr <= tx_queue;
            end else begin
               rr_ptr <= tx_queue + 3'd1;
            end
         end
      end
   end

   // total weight for the percent readout
   always_comb begin
      weight_sum = '0;
      for (int i = 0; i < NUM_Q; i++) begin
         weight_sum = weight_sum + 10'(queue_weight_entry[i]);
      end
   end

   // ahb-lite: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // address phase capture
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
      end else begin
         wr_pend <= hsel && hready && htrans[1] && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // register writes in the data phase
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strict_order_mode <= 1'b1;
         p_rate <= RATE_RST;
         p_unit <= 1'b0;
         p_shape_en <= 1'b0;
         q_unit <= '0;
         q_shape_en <= '0;
         q_excess <= '0;
         for (int i = 0; i < NUM_Q; i++) begin
            queue_weight_entry[i] <= WEIGHT_RST;
            q_rate[i] <= RATE_RST;
         end
      end else if (wr_pend) begin
         if (wr_addr == MODE_OFF) begin
            strict_order_mode <= hwdata[0];
         end else if (wr_addr == PSHAPE_OFF) begin
            if (rate_ok(hwdata[19:0], hwdata[UNIT_BIT])) begin
               p_rate <= hwdata[19:0];
               p_unit <= hwdata[UNIT_BIT];
            end
            p_shape_en <= hwdata[EN_BIT];
         end else if (wr_addr[7:5] == QSHAPE_OFF[7:5]) begin
            if (rate_ok(hwdata[19:0], hwdata[UNIT_BIT])) begin
               q_rate[wr_addr[4:2]] <= hwdata[19:0];
               q_unit[wr_addr[4:2]] <= hwdata[UNIT_BIT];
            end
            q_shape_en[wr_addr[4:2]] <= hwdata[EN_BIT];
            q_excess[wr_addr[4:2]] <= hwdata[EXCESS_BIT];
         end else if (wr_addr[7:5] == QWEIGHT_OFF[7:5]) begin
            if (hwdata[31:0] >= 32'(WEIGHT_MIN) && hwdata[31:0] <= 32'(WEIGHT_MAX)) begin
               queue_weight_entry[wr_addr[4:2]] <= hwdata[6:0];
            end
         end
      end
   end

   // read data registered at the address phase, stands in the data phase
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= '0;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         hrdata <= '0; // unmapped and reserved read zero
         if (haddr[7:0] == MODE_OFF) begin
            hrdata[0] <= strict_order_mode;
         end else if (haddr[7:0] == PSHAPE_OFF) begin
            hrdata <= {10'h000, p_shape_en, p_unit, p_rate};
         end else if (haddr[7:0] == STATUS_OFF) begin
            hrdata <= {11'h000, state == ST_BUSY, tx_queue, p_allow, q_allow, q_nonempty};
         end else if (haddr[7:5] == QSHAPE_OFF[7:5]) begin
            hrdata <= {9'h000, q_excess[haddr[4:2]], q_shape_en[haddr[4:2]],
                       q_unit[haddr[4:2]], q_rate[haddr[4:2]]};
         end else if (haddr[7:5] == QWEIGHT_OFF[7:5]) begin
            hrdata[6:0] <= queue_weight_entry[haddr[4:2]];
         end else if (haddr[7:5] == QPCT_OFF[7:5]) begin
            if (strict_order_mode) begin
               hrdata[7:0] <= PCT_NA;
            end else begin
               hrdata[7:0] <= 8'((14'(queue_weight_entry[haddr[4:2]]) * 14'd100)
                                 / 14'(weight_sum));
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: sim/tx_partner.sv
// model of the egress queues and the port transmit logic
`timescale 1ns/1ns
`default_nettype none
module tx_partner (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] backlog,
   input wire logic slow,
   input wire logic tx_valid,
   output logic [7:0] q_nonempty,
   output logic tx_ready,
   output logic tx_done,
   output logic [15:0] tx_bytes
);
   logic [3:0] cnt; // cycles of waiting or sending
   logic busy; // frame on the wire
   // queues with backlog stay non-empty, so the port is congested
   assign q_nonempty = backlog;
   // slow mode makes the scheduler hold its offer three cycles
   assign tx_ready = tx_valid && !busy && (cnt >= (slow ? 4'h3 : 4'h0));
   // length only valid with done; otherwise a pattern unlike it
   assign tx_bytes = tx_done ? 16'h0040 : 16'hFFBF;
   // accept, send for three cycles, pulse done once
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         tx_done <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         if (tx_ready) begin
            busy <= 1'b1;
            cnt <= 4'h0;
         end else if (busy && cnt == 4'h2) begin
            tx_done <= 1'b1;
            busy <= 1'b0;
            cnt <= 4'h0;
         end else if (busy || tx_valid) begin
            cnt <= cnt + 4'h1;
         end else begin
            cnt <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// file: sim/egress_sched_props.sv
// port-level checker for the egress scheduler and shaper
`timescale 1ns/1ns
`default_nettype none
module egress_sched_props
   import egress_sched_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [7:0] q_nonempty,
   input wire logic tx_valid,
   input wire logic [2:0] tx_queue,
   input wire logic tx_ready,
   input wire logic tx_done
);
   logic rd_ph, wr_ph, strict, shaped, busy;
   logic [7:0] ph_a; // address of the transfer in data phase
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // bus phase tracking
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ph <= 1'b0;
         wr_ph <= 1'b0;
         ph_a <= 8'h00;
      end else begin
         rd_ph <= hsel && hready && htrans[1] && !hwrite;
         wr_ph <= hsel && hready && htrans[1] && hwrite;
         if (hsel && hready && htrans[1]) ph_a <= haddr[7:0];
      end
   end
   // mirror of mode; shaped is sticky, any shaper use voids strict order checks
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strict <= 1'b1;
         shaped <= 1'b0;
      end else if (wr_ph) begin
         if (ph_a == MODE_OFF) strict <= hwdata[0];
         if ((ph_a == PSHAPE_OFF || ph_a[7:5] == 3'b001) && |hwdata[22:21]) shaped <= 1'b1;
      end
   end
   // one frame in flight
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) busy <= 1'b0;
      else if (tx_valid && tx_ready) busy <= 1'b1;
      else if (tx_done) busy <= 1'b0;
   end
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   offer_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_queue))
      else $error("offer dropped or changed");
   offer_cause_a: assert property ($rose(tx_valid) |-> (($past(q_nonempty) >> tx_queue) & 8'h01) != 8'h00)
      else $error("offer from empty queue");
   strict_first_a: assert property ($rose(tx_valid) && strict && !shaped |-> ($past(q_nonempty) >> tx_queue) == 8'h01)
      else $error("higher queue passed over");
   one_frame_a: assert property (busy |-> !tx_valid)
      else $error("offer while frame in flight");
   done_gap_a: assert property (busy && tx_done |=> !tx_valid)
      else $error("offer too soon after done");
   pct_na_a: assert property (rd_ph && strict && ph_a[7:5] == 3'b011 |-> hrdata[7:0] == PCT_NA)
      else $error("percent shown in strict mode");
   mode_read_a: assert property (rd_ph && ph_a == MODE_OFF |-> hrdata[0] == strict)
      else $error("mode reads wrong");
   hole_read_a: assert property (rd_ph && ((ph_a >= 8'h0C && ph_a < 8'h20) || ph_a >= 8'h80) |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   status_a: assert property (rd_ph && ph_a == STATUS_OFF |-> hrdata[7:0] == $past(q_nonempty) && hrdata[19:17] == $past(tx_queue))
      else $error("status mismatch");
   cover property ($rose(tx_valid) && strict);
   cover property ($rose(tx_valid) && !strict);
   cover property (rd_ph && ph_a[7:5] == 3'b011 && !strict);
endmodule
bind egress_port_scheduler_shaper egress_sched_props i_props (.core_clk(core_clk), .rst_n(rst_n),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .q_nonempty(q_nonempty),
   .tx_valid(tx_valid), .tx_queue(tx_queue), .tx_ready(tx_ready), .tx_done(tx_done));
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the egress scheduler and shaper
`timescale 1ns/1ns
`default_nettype none
module tb;
   import egress_sched_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, tx_valid, tx_ready, tx_done;
   logic [31:0] hrdata, r;
   logic [7:0] q_nonempty;
   logic [7:0] backlog = 8'h0; // queues holding traffic
   logic slow = 1'b0; // transmit side stalls offers
   logic [2:0] tx_queue;
   logic [15:0] tx_bytes;
   int errors = 0;
   int check_count = 0;
   int served[8]; // accepted frames per queue
   int base[8];
   always #5 core_clk = ~core_clk;
   egress_port_scheduler_shaper i_egress_port_scheduler_shaper (.core_clk(core_clk),
      .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .q_nonempty(q_nonempty), .tx_valid(tx_valid), .tx_queue(tx_queue), .tx_ready(tx_ready),
      .tx_done(tx_done), .tx_bytes(tx_bytes));
   tx_partner i_tx_partner (.core_clk(core_clk), .rst_n(rst_n), .backlog(backlog), .slow(slow),
      .tx_valid(tx_valid), .q_nonempty(q_nonempty), .tx_ready(tx_ready), .tx_done(tx_done),
      .tx_bytes(tx_bytes));
   // count accepted offers per queue
   always @(posedge core_clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) served[tx_queue]++;
   end
   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      check_count++;
      if (got_v !== exp_v) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got_v, exp_v);
      end
   endtask
   // waits for hready high at a rising edge, bounded
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge core_clk);
      while (hreadyout !== 1'b1 && n < 50) begin
         n++;
         @(posedge core_clk);
      end
      if (n == 50) errors++;
   endtask
   // one single word transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rv);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      hsel <= 1'b1;
      wait_rdy();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
      rv = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   // offer traffic for a while, then stop it
   task automatic run(input logic [7:0] b, input int cyc);
      base = served;
      backlog <= b;
      repeat (cyc) @(posedge core_clk);
      backlog <= 8'h0;
      // let an edge pass so back-to-back runs never drive backlog twice at once
      @(posedge core_clk);
   endtask
   function automatic int got(input int q);
      return served[q] - base[q];
   endfunction
   task automatic test_done;
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(MODE_OFF, 32'h1);
      rd(PSHAPE_OFF, 32'h1F4);
      for (int q = 0; q < 8; q++) begin
         rd(QSHAPE_OFF + 8'(4 * q), 32'h1F4);
         rd(QWEIGHT_OFF + 8'(4 * q), 32'h11);
         rd(QPCT_OFF + 8'(4 * q), 32'hFF);
      end
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10, 32'h0);
      rd(STATUS_OFF, 32'h0001_FF00);
      run(8'hA1, 300);
      chk(32'(got(7) > 20 && got(0) == 0), 32'h1);
      run(8'h21, 300);
      chk(32'(got(5) > 20 && got(0) == 0), 32'h1);
      wr(MODE_OFF, 32'h0);
      rd(MODE_OFF, 32'h0);
      rd(QPCT_OFF, 32'hC);
      wr(QWEIGHT_OFF, 32'hA);
      wr(QWEIGHT_OFF + 8'h4, 32'h1E);
      rd(QPCT_OFF + 8'h4, 32'h15);
      slow <= 1'b1;
      run(8'h03, 800);
      chk(32'(got(0) > 0 && got(1) > 2 * got(0)), 32'h1);
      slow <= 1'b0;
      run(8'h01, 300);
      chk(32'(got(0) > 40), 32'h1);
      wr(QWEIGHT_OFF, 32'h0);
      rd(QWEIGHT_OFF, 32'hA);
      wr(QWEIGHT_OFF, 32'h65);
      rd(QWEIGHT_OFF, 32'hA);
      wr(QWEIGHT_OFF, 32'h64);
      rd(QWEIGHT_OFF, 32'h64);
      wr(QSHAPE_OFF, 32'h63);
      rd(QSHAPE_OFF, 32'h1F4);
      wr(QSHAPE_OFF, 32'h0010_0CE5);
      rd(QSHAPE_OFF, 32'h1F4);
      wr(QSHAPE_OFF, 32'h0010_0CE4);
      rd(QSHAPE_OFF, 32'h0010_0CE4);
      wr(QSHAPE_OFF, 32'h000F_4241);
      rd(QSHAPE_OFF, 32'h0010_0CE4);
      wr(MODE_OFF, 32'h1);
      // top queue shaped to 100 Mbps: one 64 byte frame per ~512 cycles
      wr(QSHAPE_OFF + 8'h1C, 32'h0030_0064);
      run(8'h81, 1200);
      chk(32'(got(7) > 0 && got(7) < 5 && got(0) > 20), 32'h1);
      wr(QSHAPE_OFF + 8'h1C, 32'h0070_0064);
      run(8'h80, 600);
      chk(32'(got(7) > 40), 32'h1);
      wr(QSHAPE_OFF + 8'h1C, 32'h0);
      wr(PSHAPE_OFF, 32'h0030_0064);
      rd(PSHAPE_OFF, 32'h0030_0064);
      run(8'h01, 1200);
      chk(32'(got(0) > 0 && got(0) < 5), 32'h1);
      test_done();
   end
   // hang guard, well beyond the planned run
   initial begin
      #200_000;
      errors++;
      test_done();
   end
endmodule
`default_nettype wire
